/* File: design/scsd_defs.vh */
// Constants for the system clock select and divide block.
// Assumes inclusion by bare name from the design file.
`ifndef SCSD_DEFS_VH
`define SCSD_DEFS_VH

// ----------------------------------------
// Register indices, byte address = 4 * index
// ----------------------------------------
`define SCSD_IDX_HF_TRIM      8'hc7
`define SCSD_IDX_LF_CTRL      8'hb1
`define SCSD_IDX_CLK_SEL      8'ha9
`define SCSD_ADDR_W           12

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCSD_LF_EN_BIT        7
`define SCSD_LF_RDY_BIT       6
`define SCSD_LF_TRIM_HI       5
`define SCSD_LF_TRIM_LO       2
`define SCSD_LF_DIV_HI        1
`define SCSD_LF_DIV_LO        0
`define SCSD_SYS_DIV_HI       6
`define SCSD_SYS_DIV_LO       4
`define SCSD_SRC_HI           1
`define SCSD_SRC_LO           0

// ----------------------------------------
// Source select codes
// ----------------------------------------
`define SCSD_SRC_HF           2'h0
`define SCSD_SRC_EXT          2'h1
`define SCSD_SRC_LF           2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCSD_RST_SYS_DIV      3'h3
`define SCSD_RST_SRC          2'h0
`define SCSD_RST_LF_DIV       2'h0
`define SCSD_RST_LF_TRIM      4'h0
`define SCSD_RST_HF_TRIM      8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCSD_PCLK_HZ          100000000
`define SCSD_HF_HZ            24500000
`define SCSD_LF_HZ            80000
// Base periods in pclk cycles, shortest period rounds down
`define SCSD_HF_BASE_CYC      (`SCSD_PCLK_HZ / `SCSD_HF_HZ)
`define SCSD_LF_BASE_CYC      (`SCSD_PCLK_HZ / `SCSD_LF_HZ)
`define SCSD_LF_TRIM_STEP     16
`define SCSD_OSC_CNT_W        12

`endif

/* File: design/scsd_clock_ctrl.v */
// System clock source selection, post-divider and low-frequency oscillator
// control, modelled as one-cycle enable pulses on pclk.
// Assumes an APB master on pclk; external clock pin is asynchronous.
//
// Notes on behaviour
// - Three sources: HF 24.5MHz, LF 80kHz, pin.
// - Selected source post-divided by power of two.
// - Reset gives HF divided by eight.
// - HF runs whenever anyone requests it.
// - HF period follows 8-bit factory trim.
// - LF output divided by 1, 2, 4, 8.
// - LF trim field coarsely adjusts frequency.
// - LF rising edge captures timer three count.
// - Pin clock feeds peripherals under internal sources.
// - Pin clock resynchronised when not system source.
// - Pin is system source only for 01b.
// - Switching on the fly to settled sources.
// - Divider field may change any time.
// - Internal oscillators usable right after enabling.
// - Divider code 000..111 gives 1..128.
// - LF code 00..11 gives 8,4,2,1.
// - Watchdog activity forces LF on.
// - LF ready clears on reset or divider change.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "scsd_defs.vh"

module scsd_clock_ctrl #(
    parameter [7:0] HF_TRIM_FACTORY = `SCSD_RST_HF_TRIM,
    parameter [3:0] LF_TRIM_RESET   = `SCSD_RST_LF_TRIM
) (
    // APB slave
    input  wire                     pclk,
    input  wire                     presetn,
    input  wire                     psel,
    input  wire                     penable,
    input  wire                     pwrite,
    input  wire [`SCSD_ADDR_W-1:0]  paddr,
    input  wire [31:0]              pwdata,
    output reg  [31:0]              prdata,
    output reg                      pready,
    output reg                      pslverr,
    // External clock pin and consumers
    input  wire                     external_clock_pin,
    input  wire                     hf_request,
    input  wire                     watchdog_active,
    // Timer three capture hook
    input  wire                     lf_capture_mode,
    input  wire [15:0]              timer_three_count,
    output reg  [15:0]              timer_three_reload,
    output reg                      timer_three_capture,
    // Clock outputs
    output reg                      system_clock,
    output reg                      ext_periph_tick,
    output reg                      hf_running,
    output reg                      lf_running
);

    // ----------------------------------------
    // Decode functions
    // ----------------------------------------
    function [6:0] sys_div_last;
        input [2:0] code;
        begin
            sys_div_last = (7'h01 << code) - 7'h01;
        end
    endfunction

    function [2:0] lf_div_last;
        input [1:0] code;
        begin
            case (code)
                2'h0:    lf_div_last = 3'h7;
                2'h1:    lf_div_last = 3'h3;
                2'h2:    lf_div_last = 3'h1;
                default: lf_div_last = 3'h0;
            endcase
        end
    endfunction

    // Reserved code 11 behaves as the HF source
    function is_hf_code;
        input [1:0] code;
        begin
            is_hf_code = (code != `SCSD_SRC_EXT) && (code != `SCSD_SRC_LF);
        end
    endfunction

    function [`SCSD_ADDR_W-1:0] reg_addr;
        input [7:0] idx;
        begin
            reg_addr = {2'h0, idx, 2'h0};
        end
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0] hf_trim_r;
    reg       lf_en_r;
    reg       lf_rdy_r;
    reg [3:0] lf_trim_r;
    reg [1:0] lf_div_r;
    reg [2:0] sys_div_r;
    reg [1:0] src_r;

    wire apb_acc  = psel & penable & pready;
    wire apb_wr   = apb_acc & pwrite;
    wire hit_hf   = (paddr == reg_addr(`SCSD_IDX_HF_TRIM));
    wire hit_lf   = (paddr == reg_addr(`SCSD_IDX_LF_CTRL));
    wire hit_sel  = (paddr == reg_addr(`SCSD_IDX_CLK_SEL));
    wire wr_lf    = apb_wr & hit_lf;
    wire lf_div_chg = wr_lf &
        (pwdata[`SCSD_LF_DIV_HI:`SCSD_LF_DIV_LO] != lf_div_r);

    reg [7:0] rd_nxt;
    always @* begin
        rd_nxt = 8'h00;
        if (hit_hf) begin
            rd_nxt = hf_trim_r;
        end else if (hit_lf) begin
            rd_nxt = {lf_en_r, lf_rdy_r, lf_trim_r, lf_div_r};
        end else if (hit_sel) begin
            rd_nxt = {1'b0, sys_div_r, 2'h0, src_r};
        end
    end

    // Two-cycle access phase keeps prdata straight from a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~(hit_hf | hit_lf | hit_sel);
            if (psel & penable & ~pready & ~pwrite) begin
                prdata <= {24'h00_0000, rd_nxt};
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hf_trim_r <= HF_TRIM_FACTORY;
            lf_en_r   <= 1'b0;
            lf_trim_r <= LF_TRIM_RESET;
            lf_div_r  <= `SCSD_RST_LF_DIV;
            sys_div_r <= `SCSD_RST_SYS_DIV;
            src_r     <= `SCSD_RST_SRC;
        end else if (apb_wr) begin
            if (hit_hf) begin
                hf_trim_r <= pwdata[7:0];
            end else if (hit_lf) begin
                lf_en_r   <= pwdata[`SCSD_LF_EN_BIT];
                lf_trim_r <= pwdata[`SCSD_LF_TRIM_HI:`SCSD_LF_TRIM_LO];
                lf_div_r  <= pwdata[`SCSD_LF_DIV_HI:`SCSD_LF_DIV_LO];
            end else if (hit_sel) begin
                // Accepted at any time; takes hold at next boundary
                sys_div_r <= pwdata[`SCSD_SYS_DIV_HI:`SCSD_SYS_DIV_LO];
                src_r     <= pwdata[`SCSD_SRC_HI:`SCSD_SRC_LO];
            end
        end
    end

    // ----------------------------------------
    // High-frequency oscillator model
    // ----------------------------------------
    // Period in pclk cycles grows with trim; no start-up wait
    reg  [1:0]                 src_act_r;
    reg  [`SCSD_OSC_CNT_W-1:0] hf_cnt_r;
    reg                        hf_tick;
    // Code 11 runs from HF too, so it must keep HF alive
    wire                       hf_on = hf_request | is_hf_code(src_r) |
                                       is_hf_code(src_act_r);
    // Full-width sum, cut on purpose; the period never needs 12 bits
    wire [31:0]                hf_last_w =
        `SCSD_HF_BASE_CYC - 1 + {24'h00_0000, hf_trim_r};
    wire [`SCSD_OSC_CNT_W-1:0] hf_last = hf_last_w[`SCSD_OSC_CNT_W-1:0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hf_cnt_r <= {`SCSD_OSC_CNT_W{1'b0}};
            hf_tick  <= 1'b0;
        end else if (!hf_on) begin
            hf_cnt_r <= {`SCSD_OSC_CNT_W{1'b0}};
            hf_tick  <= 1'b0;
        end else if (hf_cnt_r >= hf_last) begin
            hf_cnt_r <= {`SCSD_OSC_CNT_W{1'b0}};
            hf_tick  <= 1'b1;
        end else begin
            hf_cnt_r <= hf_cnt_r + 1'b1;
            hf_tick  <= 1'b0;
        end
    end

    // ----------------------------------------
    // Low-frequency oscillator model and divider
    // ----------------------------------------
    wire lf_on = lf_en_r | watchdog_active;
    reg  [`SCSD_OSC_CNT_W-1:0] lf_cnt_r;
    reg  [2:0]                 lf_div_cnt_r;
    reg                        lf_tick;
    // Trim lengthens the period in coarse steps
    wire [31:0]                lf_last_w = `SCSD_LF_BASE_CYC - 1 +
        {28'h000_0000, lf_trim_r} * `SCSD_LF_TRIM_STEP;
    wire [`SCSD_OSC_CNT_W-1:0] lf_last = lf_last_w[`SCSD_OSC_CNT_W-1:0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lf_cnt_r     <= {`SCSD_OSC_CNT_W{1'b0}};
            lf_div_cnt_r <= 3'h0;
            lf_tick      <= 1'b0;
            lf_rdy_r     <= 1'b0;
        end else begin
            lf_tick <= 1'b0;
            if (!lf_on) begin
                lf_cnt_r <= {`SCSD_OSC_CNT_W{1'b0}};
                // Stopped oscillator restarts its divided phase
                lf_div_cnt_r <= 3'h0;
            end else if (lf_cnt_r >= lf_last) begin
                lf_cnt_r <= {`SCSD_OSC_CNT_W{1'b0}};
                if (lf_div_cnt_r >= lf_div_last(lf_div_r)) begin
                    lf_div_cnt_r <= 3'h0;
                    lf_tick      <= 1'b1;
                end else begin
                    lf_div_cnt_r <= lf_div_cnt_r + 3'h1;
                end
            end else begin
                lf_cnt_r <= lf_cnt_r + 1'b1;
            end
            // Divider change restarts the divided phase
            if (lf_div_chg) begin
                lf_div_cnt_r <= 3'h0;
                lf_rdy_r     <= 1'b0;
            end else if (lf_tick) begin
                // Sticky once the divided output has run one period
                lf_rdy_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Timer three capture hook
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_three_reload  <= 16'h0000;
            timer_three_capture <= 1'b0;
        end else begin
            timer_three_capture <= lf_capture_mode & lf_tick;
            if (lf_capture_mode & lf_tick) begin
                timer_three_reload <= timer_three_count;
            end
        end
    end

    // ----------------------------------------
    // External clock pin
    // ----------------------------------------
    reg ext_s1_r;
    reg ext_s2_r;
    reg ext_s3_r;
    wire ext_tick = ext_s2_r & ~ext_s3_r;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_r        <= 1'b0;
            ext_s2_r        <= 1'b0;
            ext_s3_r        <= 1'b0;
            ext_periph_tick <= 1'b0;
        end else begin
            ext_s1_r        <= external_clock_pin;
            ext_s2_r        <= ext_s1_r;
            ext_s3_r        <= ext_s2_r;
            // Available to peripherals whatever the system source
            ext_periph_tick <= ext_tick;
        end
    end

    // ----------------------------------------
    // Source multiplexer and post-divider
    // ----------------------------------------
    // Selection and ratio only change after a whole divided period, so no
    // shortened phase appears. A dead source stalls the switch for good.
    // The first tick of a new source only aligns the divider.
    reg [2:0] div_act_r;
    reg [6:0] sys_cnt_r;
    reg       src_tick;
    reg       align_r;

    always @* begin
        case (src_act_r)
            `SCSD_SRC_EXT: src_tick = ext_tick;
            `SCSD_SRC_LF:  src_tick = lf_tick;
            default:       src_tick = hf_tick;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_act_r    <= `SCSD_RST_SRC;
            div_act_r    <= `SCSD_RST_SYS_DIV;
            sys_cnt_r    <= 7'h00;
            align_r      <= 1'b0;
            system_clock <= 1'b0;
        end else begin
            system_clock <= 1'b0;
            if (src_tick) begin
                if (align_r) begin
                    // New source may tick right after the switch pulse
                    align_r      <= 1'b0;
                end else if (sys_cnt_r >= sys_div_last(div_act_r)) begin
                    sys_cnt_r    <= 7'h00;
                    system_clock <= 1'b1;
                    src_act_r    <= src_r;
                    div_act_r    <= sys_div_r;
                    align_r      <= (src_r != src_act_r);
                end else begin
                    sys_cnt_r <= sys_cnt_r + 7'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // Oscillator status outputs
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hf_running <= 1'b0;
            lf_running <= 1'b0;
        end else begin
            hf_running <= hf_on;
            lf_running <= lf_on;
        end
    end

endmodule
`default_nettype wire

/* File: verification/scsd_ext_clk_src.sv */
// External CMOS clock source for the pin input.
// Assumes a 1ns timescale; stands low while disabled.
`timescale 1ns/1ps
`default_nettype none
module scsd_ext_clk_src #(
    parameter int HALF_NS = 200
) (
    input  wire logic enable,
    output var  logic clk_out
);
    initial clk_out = 1'b0;
    // Edges land on pclk falling edges, fixed in phase
    // Plain digital level, as from a pin kept out of the crossbar
    always begin
        #(HALF_NS);
        clk_out = enable ? ~clk_out : 1'b0;
    end
endmodule
`default_nettype wire

/* File: verification/scsd_monitor.sv */
// Port checker for the clock select and divide block.
// Assumes pclk with asynchronous active-low presetn.
`timescale 1ns/1ps
`default_nettype none
module scsd_monitor (
    // Bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Clock side
    input wire logic        external_clock_pin,
    input wire logic        hf_request,
    input wire logic        watchdog_active,
    input wire logic        lf_capture_mode,
    input wire logic [15:0] timer_three_reload,
    input wire logic        timer_three_capture,
    input wire logic        system_clock,
    input wire logic        ext_periph_tick,
    input wire logic        hf_running,
    input wire logic        lf_running
);
    wire logic mapped = paddr == 12'h31c || paddr == 12'h2c4 || paddr == 12'h2a4;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready not one cycle");
    error_decode_a: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong");
    read_clean_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0
        && (mapped || prdata[7:0] == 8'h00)) else $error("read data dirty");
    hf_on_request_a: assert property (hf_request |=> hf_running)
        else $error("hf not running");
    lf_forced_on_a: assert property (watchdog_active |=> lf_running)
        else $error("lf not forced");
    no_runt_a: assert property (system_clock |=> !system_clock [*3])
        else $error("system clock runt");
    ext_sync_tick_a: assert property ($rose(external_clock_pin)
        |-> ##[2:6] ext_periph_tick) else $error("ext tick missing");
    capture_pair_a: assert property ($changed(timer_three_reload)
        |-> timer_three_capture && $past(lf_capture_mode)) else $error("stray capture");
endmodule
bind scsd_clock_ctrl scsd_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_clock_pin(external_clock_pin), .hf_request(hf_request),
    .watchdog_active(watchdog_active), .lf_capture_mode(lf_capture_mode),
    .timer_three_reload(timer_three_reload), .timer_three_capture(timer_three_capture),
    .system_clock(system_clock), .ext_periph_tick(ext_periph_tick),
    .hf_running(hf_running), .lf_running(lf_running));
`default_nettype wire

/* File: verification/scsd_clock_ctrl_tb_top.sv */
// Bench for the clock select and divide block over APB.
// Assumes the external clock model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module scsd_clock_ctrl_tb_top;
    localparam logic [11:0] A_HF = 12'h31c;
    localparam logic [11:0] A_LF = 12'h2c4;
    localparam logic [11:0] A_SEL = 12'h2a4;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, ext_en, hf_request, watchdog_active;
    logic        lf_capture_mode, pready, pslverr, errs, external_clock_pin;
    logic        timer_three_capture, system_clock, ext_periph_tick, hf_running, lf_running;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] timer_three_count, timer_three_reload, cap0;
    int          fails = 0, comparisons = 0, cyc = 0;
    scsd_ext_clk_src #(.HALF_NS(200)) u_ext (.enable(ext_en), .clk_out(external_clock_pin));
    scsd_clock_ctrl #(.HF_TRIM_FACTORY(8'h02), .LF_TRIM_RESET(4'h0)) DUT (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_clock_pin(external_clock_pin), .hf_request(hf_request),
        .watchdog_active(watchdog_active), .lf_capture_mode(lf_capture_mode),
        .timer_three_count(timer_three_count), .timer_three_reload(timer_three_reload),
        .timer_three_capture(timer_three_capture), .system_clock(system_clock),
        .ext_periph_tick(ext_periph_tick), .hf_running(hf_running), .lf_running(lf_running));
    always #5 pclk = ~pclk;
    // Free timer for capture, plus the hang limit
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        timer_three_count <= timer_three_count + 16'h0001;
        if (cyc == 90000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            fails++;
        end
    endtask
    // Holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        errs = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        check(nm, exp, rdat);
    endtask
    task automatic pulse(input int s);
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((s == 0 ? system_clock : s == 1 ? ext_periph_tick : timer_three_capture)
                   !== 1'b1 && n < 20000);
        if (n >= 20000) fails++;
    endtask
    // First pulse closes the old setting, second the first new period
    task automatic period(input int s, input int exp, input string nm);
        int t0;
        pulse(s);
        pulse(s);
        t0 = cyc;
        pulse(s);
        check(nm, exp, cyc - t0);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, ext_en, hf_request} = 6'h00;
        {watchdog_active, lf_capture_mode} = 2'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        timer_three_count = 16'h0000;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_HF, 32'h02, "hf trim reset");
        rd(A_LF, 32'h00, "lf ctrl reset");
        rd(A_SEL, 32'h30, "clk sel reset");
        period(0, 48, "hf div8");
        apb(1'b1, A_HF, 32'h00);
        for (int d = 0; d < 8; d++) begin
            apb(1'b1, A_SEL, {25'h0, d[2:0], 4'h0});
            period(0, 4 << d, "sys div");
        end
        $display("test divider done");
        ext_en <= 1'b1;
        period(1, 40, "ext tick");
        apb(1'b1, A_SEL, 32'hff);
        rd(A_SEL, 32'h73, "clk sel reserved");
        period(0, 512, "code 11 on hf");
        apb(1'b1, A_SEL, 32'h01);
        period(0, 40, "ext system");
        $display("test external done");
        lf_capture_mode <= 1'b1;
        apb(1'b1, A_LF, 32'h87);
        pulse(2);
        rd(A_LF, 32'hc7, "lf ready");
        pulse(2);
        cap0 = timer_three_reload;
        pulse(2);
        check("capture step", 32'd1266, {16'h0, timer_three_reload - cap0});
        apb(1'b1, A_SEL, 32'h02);
        period(0, 1266, "lf system");
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, A_LF, 32'h84 | c);
            rd(A_LF, 32'h84 | c, "lf ready cleared");
            period(0, 1266 * (8 >> c), "lf div");
        end
        $display("test low frequency done");
        hf_request <= 1'b1;
        watchdog_active <= 1'b1;
        apb(1'b1, A_LF, 32'h07);
        rd(A_LF, 32'h47, "lf ready kept");
        check("hf on request", 32'h1, {31'h0, hf_running});
        check("lf forced", 32'h1, {31'h0, lf_running});
        hf_request <= 1'b0;
        watchdog_active <= 1'b0;
        repeat (3) @(posedge pclk);
        check("hf released", 32'h0, {31'h0, hf_running});
        check("lf released", 32'h0, {31'h0, lf_running});
        apb(1'b0, 12'h000, 32'h0);
        check("unmapped err", 32'h1, {31'h0, errs});
        check("unmapped data", 32'h0, rdat);
        $display("test watchdog and decode done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(A_SEL, 32'h30, "clk sel after reset");
        rd(A_LF, 32'h00, "lf ctrl after reset");
        rd(A_HF, 32'h02, "hf trim after reset");
        period(0, 48, "hf div8 after reset");
        $display("test reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
